// [core/adc_status_regs.v]
`timescale 1ns/10ps
`default_nettype none
`include "adc_status_defs.vh"

module adc_status_regs #(
    parameter        NUM_CH       = 4,                      // Number of converter channels
    parameter        SAMPLE_W     = 32,                     // Width of one stored result
    parameter [3:0]  ID_UPPER     = 4'h5,                   // Arbitrary value, upper id nibble
    parameter [7:0]  ID_REVISION  = 8'hA5                   // Arbitrary value, revision byte
) (
    input  wire                       i_core_clk,           // Core clock, 125 MHz
    input  wire                       i_srst,               // Synchronous reset, active high
    // Wishbone classic slave
    input  wire                       i_wb_cyc,             // Bus cycle
    input  wire                       i_wb_stb,             // Strobe
    input  wire                       i_wb_we,              // Write enable
    input  wire [7:0]                 i_wb_adr,             // Byte address
    input  wire [3:0]                 i_wb_sel,             // Byte lane selects
    input  wire [31:0]                i_wb_dat,             // Write data
    output reg  [31:0]                o_wb_dat,             // Read data
    output reg                        o_wb_ack,             // Acknowledge
    // Converter side
    input  wire                       i_iface_locked,       // Interface lock level
    input  wire                       i_realign_event,      // Resynchronization pulse
    input  wire                       i_regmap_crc_changed, // Register map checksum change pulse
    input  wire                       i_rx_crc_error,       // Input checksum error pulse
    input  wire [NUM_CH-1:0]          i_sample_valid,       // Per-channel new result pulse
    input  wire [NUM_CH*SAMPLE_W-1:0] i_sample_data,        // Per-channel results
    // Outputs
    output reg  [15:0]                o_mode_cfg,           // Mode configuration to the converter
    output reg                        o_irq                 // Interrupt, active high level
);

    localparam [15:0] ID_VALUE = {ID_UPPER, `CHANNEL_TOTAL_VALUE, ID_REVISION};

    reg  [NUM_CH-1:0]          new_sample_reg;
    reg  [NUM_CH-1:0]          new_sample_next;
    reg  [NUM_CH*SAMPLE_W-1:0] result_reg;
    reg                        lock_reg;
    reg                        realign_reg;
    reg                        realign_next;
    reg                        regmap_reg;
    reg                        regmap_next;
    reg                        crc_err_reg;
    reg                        crc_err_next;
    reg                        reset_flag_reg;
    reg                        reset_flag_next;
    reg  [15:0]                mode_reg;
    reg  [15:0]                mode_next;
    reg  [`IRQ_WIDTH-1:0]      irq_stat_reg;
    reg  [`IRQ_WIDTH-1:0]      irq_stat_next;
    reg  [`IRQ_WIDTH-1:0]      irq_mask_reg;
    reg  [`IRQ_WIDTH-1:0]      irq_mask_next;
    reg  [31:0]                rdata_next;
    reg  [15:0]                status_value;
    reg  [NUM_CH-1:0]          result_read;
    reg  [`IRQ_WIDTH-1:0]      irq_events;

    wire                       access;
    wire                       wr_access;
    wire                       rd_access;
    wire [5:0]                 reg_idx;
    wire [5:0]                 ch_ofs;
    wire                       ch_hit;
    wire                       status_read;

    // A held strobe is not taken again while its registered ack stands
    assign access      = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wr_access   = access & i_wb_we;
    assign rd_access   = access & ~i_wb_we;
    assign reg_idx     = i_wb_adr[7:2];
    assign ch_ofs      = reg_idx - `IDX_CH_RESULT_BASE;
    assign ch_hit      = (reg_idx >= `IDX_CH_RESULT_BASE) &&
                         (reg_idx < (`IDX_CH_RESULT_BASE + NUM_CH[5:0]));
    assign status_read = rd_access && (reg_idx == `IDX_CONVERTER_STATUS);

    // Assembled status word; every field is read only
    always @* begin
        status_value                   = 16'h0000;
        status_value[`ST_LOCK_BIT]     = lock_reg;
        status_value[`ST_REALIGN_BIT]  = realign_reg;
        status_value[`ST_REGMAP_BIT]   = regmap_reg;
        status_value[`ST_CRC_ERR_BIT]  = crc_err_reg;
        status_value[`ST_CRC_TYPE_BIT] = mode_reg[`MD_CRC_TYPE_BIT];
        status_value[`ST_RESET_BIT]    = reset_flag_reg;
        status_value[`ST_WSIZE_HI:`ST_WSIZE_LO] =
            mode_reg[`MD_WSIZE_HI:`MD_WSIZE_LO];
        status_value[NUM_CH-1:0]       = new_sample_reg;
    end

    // Which channel result is being read in this access, one-hot
    always @* begin
        result_read = {NUM_CH{1'b0}};
        if (rd_access && ch_hit) begin
            result_read = {{(NUM_CH-1){1'b0}}, 1'b1} << ch_ofs;
        end
    end

    // Per-channel result store, loaded by that channel's new-result pulse
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
            always @(posedge i_core_clk) begin
                if (i_srst) begin
                    result_reg[g*SAMPLE_W +: SAMPLE_W] <= {SAMPLE_W{1'b0}};
                end else if (i_sample_valid[g]) begin
                    result_reg[g*SAMPLE_W +: SAMPLE_W] <= i_sample_data[g*SAMPLE_W +: SAMPLE_W];
                end
            end
        end
    endgenerate

    // New-sample flags: a fresh result wins over the clearing read
    always @* begin
        new_sample_next = (new_sample_reg & ~result_read) | i_sample_valid;
    end

    // Sticky event flags: a status read clears them, an event in the same cycle wins
    always @* begin
        realign_next = realign_reg;
        if (status_read) begin
            realign_next = 1'b0;
        end
        if (i_realign_event) begin
            realign_next = 1'b1;
        end
    end

    always @* begin
        regmap_next = regmap_reg;
        if (status_read) begin
            regmap_next = 1'b0;
        end
        if (i_regmap_crc_changed) begin
            regmap_next = 1'b1;
        end
    end

    always @* begin
        crc_err_next = crc_err_reg;
        if (status_read) begin
            crc_err_next = 1'b0;
        end
        if (i_rx_crc_error) begin
            crc_err_next = 1'b1;
        end
    end

    // Mode configuration writes, lane by lane; every bit is stored as written
    always @* begin
        mode_next = mode_reg;
        if (wr_access && (reg_idx == `IDX_MODE_CONFIGURATION)) begin
            if (i_wb_sel[0]) begin
                mode_next[7:0] = i_wb_dat[7:0];
            end
            if (i_wb_sel[1]) begin
                mode_next[15:8] = i_wb_dat[15:8];
            end
        end
    end

    // Reset-occurred flag: only a written zero in the mode reset bit clears it
    always @* begin
        reset_flag_next = reset_flag_reg;
        if (wr_access && (reg_idx == `IDX_MODE_CONFIGURATION) && i_wb_sel[1] &&
            !i_wb_dat[`MD_RESET_BIT]) begin
            reset_flag_next = 1'b0;
        end
    end

    // Interrupt sources, one per event
    always @* begin
        irq_events                   = {`IRQ_WIDTH{1'b0}};
        irq_events[NUM_CH-1:0]       = i_sample_valid;
        irq_events[`IRQ_REALIGN_BIT] = i_realign_event;
        irq_events[`IRQ_REGMAP_BIT]  = i_regmap_crc_changed;
        irq_events[`IRQ_CRC_ERR_BIT] = i_rx_crc_error;
    end

    // Interrupt status: write one to clear; a new event in the same cycle wins
    always @* begin
        irq_stat_next = irq_stat_reg;
        if (wr_access && i_wb_sel[0] && (reg_idx == `IDX_IRQ_STATUS)) begin
            irq_stat_next = irq_stat_reg & ~i_wb_dat[`IRQ_WIDTH-1:0];
        end
        irq_stat_next = irq_stat_next | irq_events;
    end

    // Interrupt mask, same layout as the status
    always @* begin
        irq_mask_next = irq_mask_reg;
        if (wr_access && i_wb_sel[0] && (reg_idx == `IDX_IRQ_MASK)) begin
            irq_mask_next = i_wb_dat[`IRQ_WIDTH-1:0];
        end
    end

    // Read data multiplexer; unmapped indices read zero
    always @* begin
        rdata_next = 32'h0000_0000;
        case (reg_idx)
            `IDX_DEVICE_IDENTIFICATION: begin
                rdata_next[15:0] = ID_VALUE;
            end
            `IDX_CONVERTER_STATUS: begin
                rdata_next[15:0] = status_value;
            end
            `IDX_MODE_CONFIGURATION: begin
                rdata_next[15:0] = mode_reg;
            end
            `IDX_IRQ_STATUS: begin
                rdata_next[`IRQ_WIDTH-1:0] = irq_stat_reg;
            end
            `IDX_IRQ_MASK: begin
                rdata_next[`IRQ_WIDTH-1:0] = irq_mask_reg;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
        if ((reg_idx >= `IDX_CH_RESULT_BASE) &&
            (reg_idx < (`IDX_CH_RESULT_BASE + NUM_CH[5:0]))) begin
            rdata_next = 32'h0000_0000;
            rdata_next[SAMPLE_W-1:0] =
                result_reg[(reg_idx - `IDX_CH_RESULT_BASE) * SAMPLE_W +: SAMPLE_W];
        end
    end

    // New-sample flags
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            new_sample_reg <= {NUM_CH{1'b0}};
        end else begin
            new_sample_reg <= new_sample_next;
        end
    end

    // Interface lock, one cycle behind its input
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            lock_reg <= 1'b0;
        end else begin
            lock_reg <= i_iface_locked;
        end
    end

    // Resynchronization flag
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            realign_reg <= 1'b0;
        end else begin
            realign_reg <= realign_next;
        end
    end

    // Register map checksum change flag
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            regmap_reg <= 1'b0;
        end else begin
            regmap_reg <= regmap_next;
        end
    end

    // Input checksum error flag
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            crc_err_reg <= 1'b0;
        end else begin
            crc_err_reg <= crc_err_next;
        end
    end

    // Reset-occurred flag, set only by reset
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            reset_flag_reg <= 1'b1;
        end else begin
            reset_flag_reg <= reset_flag_next;
        end
    end

    // Mode configuration register
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            mode_reg <= `RST_MODE_CONFIGURATION;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Interrupt status
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            irq_stat_reg <= {`IRQ_WIDTH{1'b0}};
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    // Interrupt mask
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            irq_mask_reg <= {`IRQ_WIDTH{1'b0}};
        end else begin
            irq_mask_reg <= irq_mask_next;
        end
    end

    // Bus acknowledge, one cycle per taken request
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= access;
        end
    end

    // Read data, held until the next read is taken
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (rd_access) begin
            o_wb_dat <= rdata_next;
        end
    end

    // Mode configuration to the converter, equal to the readback value
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_mode_cfg <= `RST_MODE_CONFIGURATION;
        end else begin
            o_mode_cfg <= mode_next;
        end
    end

    // Interrupt level from next status and mask, so it leaves a flip-flop in step
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat_next & irq_mask_next);
        end
    end

endmodule // adc_status_regs
`default_nettype wire

// [core/adc_status_defs.vh]
`ifndef ADC_STATUS_DEFS_VH
`define ADC_STATUS_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_DEVICE_IDENTIFICATION 6'h00
`define IDX_CONVERTER_STATUS      6'h01
`define IDX_MODE_CONFIGURATION    6'h02
`define IDX_IRQ_STATUS            6'h04
`define IDX_IRQ_MASK              6'h05
`define IDX_CH_RESULT_BASE        6'h08

`define RST_CONVERTER_STATUS      16'h0500
`define RST_MODE_CONFIGURATION    16'h0510
`define CHANNEL_TOTAL_VALUE       4'h4

// Status fields
`define ST_LOCK_BIT       15
`define ST_REALIGN_BIT    14
`define ST_REGMAP_BIT     13
`define ST_CRC_ERR_BIT    12
`define ST_CRC_TYPE_BIT   11
`define ST_RESET_BIT      10
`define ST_WSIZE_HI       9
`define ST_WSIZE_LO       8

// Mode fields
`define MD_CRC_TYPE_BIT   11
`define MD_RESET_BIT      10
`define MD_WSIZE_HI       9
`define MD_WSIZE_LO       8

// Interrupt status bits
`define IRQ_REALIGN_BIT   4
`define IRQ_REGMAP_BIT    5
`define IRQ_CRC_ERR_BIT   6
`define IRQ_WIDTH         7

`endif

// [tb/adc_status_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module adc_status_monitor #(
    parameter int NUM_CH = 4                        // Channels
) (
    input wire logic              i_core_clk,           // Clock
    input wire logic              i_srst,               // Reset
    input wire logic              i_wb_cyc,             // Cycle
    input wire logic              i_wb_stb,             // Strobe
    input wire logic              i_wb_we,              // Write
    input wire logic [7:0]        i_wb_adr,             // Address
    input wire logic [31:0]       i_wb_dat,             // Write data
    input wire logic [3:0]        i_wb_sel,             // Lanes
    input wire logic [31:0]       o_wb_dat,             // Read data
    input wire logic              o_wb_ack,             // Ack
    input wire logic              i_iface_locked,       // Lock
    input wire logic              i_realign_event,      // Resync
    input wire logic              i_regmap_crc_changed, // Map change
    input wire logic              i_rx_crc_error,       // Input error
    input wire logic [NUM_CH-1:0] i_sample_valid,       // New samples
    input wire logic [15:0]       o_mode_cfg,           // Mode
    input wire logic              o_irq                 // Interrupt
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    logic [5:0] idx;
    logic       take;
    logic       rd_st;
    logic [2:0] ev_pend;
    logic [3:0] new_pend;
    logic       rst_flag;
    assign idx = i_wb_adr[7:2];
    assign take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign rd_st = take & ~i_wb_we & idx == 6'h01;
    // Expected sticky flags, as seen by a status read taken now
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ev_pend <= 3'h0;
            new_pend <= 4'h0;
            rst_flag <= 1'h1;
        end else begin
            ev_pend <= (rd_st ? 3'h0 : ev_pend) | {i_realign_event, i_regmap_crc_changed, i_rx_crc_error};
            new_pend <= (new_pend & ~((take & ~i_wb_we & idx[5:2] == 4'h2) ? 4'h1 << idx[1:0] : 4'h0))
                        | i_sample_valid[3:0];
            if (take & i_wb_we & idx == 6'h02 & i_wb_sel[1] & i_wb_dat[10] == 1'h0)
                rst_flag <= 1'h0;
        end
    end
    a_id_fixed: assert property (take & ~i_wb_we & idx == 6'h00 |=> o_wb_dat[11:8] == 4'h4)
        else $error("channel count field wrong");
    a_lock_follows: assert property (rd_st |=> o_wb_dat[15] == $past(i_iface_locked, 2))
        else $error("lock bit wrong");
    a_realign_flag: assert property (rd_st |=> o_wb_dat[14] == $past(ev_pend[2]))
        else $error("resync flag wrong");
    a_regmap_flag: assert property (rd_st |=> o_wb_dat[13] == $past(ev_pend[1]))
        else $error("map change flag wrong");
    a_crcerr_flag: assert property (rd_st |=> o_wb_dat[12] == $past(ev_pend[0]))
        else $error("input error flag wrong");
    a_mode_mirror: assert property (rd_st |=> o_wb_dat[11:8] == {$past(o_mode_cfg[11]), o_wb_dat[10],
        $past(o_mode_cfg[9:8])})
        else $error("mirrored mode fields wrong");
    a_reset_flag: assert property (rd_st |=> o_wb_dat[10] == $past(rst_flag))
        else $error("reset flag wrong");
    a_new_sample: assert property (rd_st |=> o_wb_dat[3:0] == $past(new_pend))
        else $error("new sample flags wrong");
    a_status_fixed: assert property (rd_st |=> o_wb_dat[31:16] == 16'h0 && o_wb_dat[7:4] == 4'h0)
        else $error("status reserved bits set");
    a_mode_reset: assert property ($fell(i_srst) |-> o_mode_cfg == 16'h0510)
        else $error("mode reset value wrong");
    cover property (rd_st && ev_pend == 3'h7);
    cover property (rd_st && i_iface_locked);
    cover property (o_irq);
endmodule // adc_status_monitor
bind adc_status_regs adc_status_monitor #(.NUM_CH(NUM_CH)) u_mon (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
    .i_wb_sel(i_wb_sel),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_iface_locked(i_iface_locked), .i_realign_event(i_realign_event),
    .i_regmap_crc_changed(i_regmap_crc_changed), .i_rx_crc_error(i_rx_crc_error),
    .i_sample_valid(i_sample_valid), .o_mode_cfg(o_mode_cfg), .o_irq(o_irq));
`default_nettype wire

// [tb/wb_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module wb_host_model (
    input  wire logic        i_core_clk, // Clock
    output logic             o_cyc,      // Cycle
    output logic             o_stb,      // Strobe
    output logic             o_we,       // Write
    output logic [7:0]       o_adr,      // Address
    output logic [3:0]       o_sel,      // Lanes
    output logic [31:0]      o_dat,      // Write data
    input  wire logic [31:0] i_dat,      // Read data
    input  wire logic        i_ack       // Ack
);
    initial {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] q, output logic to);
        @(posedge i_core_clk);
        {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'h3, w, a, s, d};
        to = 1'h1;
        for (int n = 0; n < 50; n++) begin
            @(posedge i_core_clk);
            if (i_ack === 1'h1) begin
                q = i_dat; // Word kept whole; the caller never relies on the revision byte
                to = 1'h0;
                break;
            end
        end
        {o_cyc, o_stb} <= 2'h0;
        {o_adr, o_dat} <= {~a, ~d};
    endtask
endmodule // wb_host_model
`default_nettype wire

// [tb/adc_status_id_registers_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module adc_status_id_registers_tb_top;
    logic         clk, srst, lock, cyc, stb, we, ack, irq;
    logic [6:0]   ev;
    logic [127:0] sd;
    logic [7:0]   adr;
    logic [3:0]   sel;
    logic [31:0]  wdat, rdat, q;
    logic [15:0]  mode;
    int           comparisons, n_mismatch;
    adc_status_regs u_dut (.i_core_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_iface_locked(lock), .i_realign_event(ev[0]), .i_regmap_crc_changed(ev[1]), .i_rx_crc_error(ev[2]),
        .i_sample_valid(ev[6:3]), .i_sample_data(sd), .o_mode_cfg(mode), .o_irq(irq));
    wb_host_model u_host (.i_core_clk(clk), .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel),
        .o_dat(wdat), .i_dat(rdat), .i_ack(ack));
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    task automatic end_sim;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic exp);
        repeat (2) @(negedge clk);
        comparisons++;
        if (irq !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t interrupt %b expected %b", $time, irq, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic to;
        u_host.xfer(w, a, d, 4'hF, q, to);
        if (to) begin
            n_mismatch++;
            $display("[ERR] %0t bus answer timed out", $time);
            end_sim();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic pulse(input logic [6:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 7'h00;
    endtask
    task automatic t_reset;
        bus(1'h1, 8'h00, 32'h0000_FFFF);
        bus(1'h1, 8'h04, 32'h0000_FFFF);
        bus(1'h0, 8'h00, 32'h0);
        chk(q & 32'hFFFF_0F00, 32'h0000_0400);
        rd_chk(8'h04, 32'h0000_0500);
        rd_chk(8'h08, 32'h0000_0510);
        rd_chk(8'h3C, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_events;
        pulse(7'h7F);
        rd_chk(8'h04, 32'h0000_750F);
        rd_chk(8'h04, 32'h0000_050F);
        for (int i = 0; i < 4; i++)
            rd_chk(8'(8'h20 + 4 * i), sd[32*i +: 32]);
        rd_chk(8'h04, 32'h0000_0500);
        for (int j = 0; j < 3; j++) begin
            pulse(7'h01 << j);
            rd_chk(8'h04, 32'h0000_0500 | (32'h0000_4000 >> j));
        end
        chk_irq(1'h0);
        bus(1'h1, 8'h14, 32'h10);
        chk_irq(1'h1);
        bus(1'h1, 8'h10, 32'h7F);
        chk_irq(1'h0);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h14, 32'h10);
        @(posedge clk);
        lock <= 1'h1;
        rd_chk(8'h04, 32'h0000_8500);
        @(posedge clk);
        lock <= 1'h0;
        rd_chk(8'h04, 32'h0000_0500);
        $display("t_events done");
    endtask
    task automatic t_mode;
        logic [31:0] d;
        for (int i = 0; i < 8; i++) begin
            d = {20'h0, i[2], 1'h1, i[1:0], 8'h10};
            bus(1'h1, 8'h08, d);
            chk({16'h0, mode}, d);
            rd_chk(8'h08, d);
            rd_chk(8'h04, d & 32'h0F00);
        end
        bus(1'h1, 8'h08, 32'h0110);
        rd_chk(8'h04, 32'h0100);
        bus(1'h1, 8'h08, 32'h0510);
        rd_chk(8'h04, 32'h0100);
        @(posedge clk);
        srst <= 1'h1;
        repeat (4) @(posedge clk);
        srst <= 1'h0;
        rd_chk(8'h04, 32'h0500);
        rd_chk(8'h08, 32'h0510);
        chk({16'h0, mode}, 32'h0510);
        $display("t_mode done");
    endtask
    initial begin
        srst = 1'h1;
        lock = 1'h0;
        ev = 7'h00;
        sd = 128'h3333_0D0D_2222_0C0C_1111_0B0B_0000_0A0A;
        repeat (4) @(posedge clk);
        srst <= 1'h0;
        t_reset();
        t_events();
        t_mode();
        end_sim();
    end
endmodule // adc_status_id_registers_tb_top
`default_nettype wire
